// >>> core/iqr_defs.svh
`ifndef IQR_DEFS_SVH
`define IQR_DEFS_SVH

// Retry budget for the secondary interlock
`define IQR_RETRY_INIT      8'h14
// Link offsets inside a header or entry
`define IQR_QUAD_BLINK_OFS  64'h0000_0000_0000_0008
`define IQR_LONG_BLINK_OFS  64'h0000_0000_0000_0004
// Interlock bit position in the header
`define IQR_LOCK_BIT        0
// Status codes, sign extended to 64 bits
`define IQR_ST_LOCKFAIL     64'hFFFF_FFFF_FFFF_FFFF
`define IQR_ST_EMPTY        64'h0000_0000_0000_0000
`define IQR_ST_REMAIN       64'h0000_0000_0000_0001
`define IQR_ST_NOWEMPTY     64'h0000_0000_0000_0002

`endif

// >>> core/iqr_pkg.sv
package iqr_pkg;

    typedef enum logic [1:0] {
        IQR_OP_QHEAD_RES,
        IQR_OP_LTAIL_CHK,
        IQR_OP_LTAIL_RES
    } iqr_op_t;

    typedef enum logic [1:0] {
        IQR_MEM_READ,
        IQR_MEM_WRITE,
        IQR_MEM_LOCKED_READ,
        IQR_MEM_COND_WRITE
    } iqr_mem_t;

    typedef enum logic [1:0] {
        IQR_EXC_NONE,
        IQR_EXC_ILLEGAL_OPERAND,
        IQR_EXC_MEM_FAULT
    } iqr_exc_t;

endpackage

// >>> core/iqr_sext32.sv
`timescale 1ns/1ps
// Truncate to 32 bits and sign extend back to 64
module iqr_sext32 (
    // Data
    input  wire logic [63:0] value,
    output logic      [63:0] result
);
    assign result = {{32{value[31]}}, value[31:0]};
endmodule

// >>> core/iqr_status_pick.sv
`timescale 1ns/1ps
`include "iqr_defs.svh"
// Removal status from original forward offset and new neighbour
module iqr_status_pick (
    // Inputs
    input  wire logic [63:0] origFlink,
    input  wire logic [63:0] neighbour,
    input  wire logic [63:0] header,
    // Result
    output logic      [63:0] status
);
    always_comb begin
        if (origFlink == 64'h0000_0000_0000_0000) begin
            status = `IQR_ST_EMPTY;
        end else if (neighbour == header) begin
            status = `IQR_ST_NOWEMPTY;
        end else begin
            status = `IQR_ST_REMAIN;
        end
    end
endmodule

// >>> core/iqr_remover.sv
`timescale 1ns/1ps
`include "iqr_defs.svh"
// Notes on behaviour
// - Status is -1 lock failed, 0 was empty, 1 removed and more, 2 now empty.
// - Interlock attempts are bounded, default 20; exhaustion returns -1, nothing changed.
// - Locked header read; bit 0 set gives -1, else conditional write with bit set.
// - Quad head: successor is entry plus its offset; write successor back link at 8.
// - After a barrier, header forward link becomes successor minus header, freeing lock.
// - Head removal returns header plus original forward offset as removed entry.
// - Checked tail removal faults on misaligned or non-32-bit header address first.
// - Longword offsets are low and high header halves; checked form checks back offset.
// - Checked form probes entry back link and, unless empty, header first; failure restores header, memory fault.
// - Checked form faults on a misaligned predecessor after restoring the header.
// - Tail: write header back link at 4; then forward link zero or predecessor plus restore.
// - Tail removal removes the entry before the header and returns its address.
// - Longword link arithmetic truncates to 32 bits then sign extends.
// - Resident forms skip alignment and access probes.
// - A removal runs to completion once started; start is ignored while busy.
// - Removals are interlocked against other processors through the header lock bit.
module iqr_remover #(
    parameter logic [7:0] RETRY_LIMIT = `IQR_RETRY_INIT
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Operation request
    input  wire logic             start,
    input  wire iqr_pkg::iqr_op_t opSel,
    input  wire logic [63:0]      headerAddress,
    output logic                  busy,
    output logic                  done,
    output logic [63:0]           statusResult,
    output logic [63:0]           removedEntry,
    output iqr_pkg::iqr_exc_t     exception,
    // Memory system
    output logic                  memReq,
    output iqr_pkg::iqr_mem_t     memKind,
    output logic                  memProbe,
    output logic [63:0]           memAddr,
    output logic [63:0]           memWdata,
    output logic                  memLongword,
    input  wire logic             memAck,
    input  wire logic [63:0]      memRdata,
    input  wire logic             memCondOk,
    input  wire logic             memProbeFault,
    output logic                  memoryBarrier,
    input  wire logic             barrierAck
);
    typedef enum logic [4:0] {
        S_IDLE, S_LLREAD, S_CONDWR, S_MB1, S_CHKOFS, S_PROBE1, S_PROBE2,
        S_RDLINK, S_PREDCHK, S_WRLINK1, S_MB2, S_WRFWD, S_MB3, S_WRHDR,
        S_RESTORE, S_FINISH
    } iqr_state_t;

    iqr_state_t        state_reg;
    iqr_pkg::iqr_op_t  op_reg;
    logic [63:0]       hdr_reg;
    logic [63:0]       tmp0_reg;
    logic [63:0]       entry_reg;
    logic [63:0]       neigh_reg;
    logic [7:0]        retry_reg;
    iqr_pkg::iqr_exc_t pendExc_reg;
    logic              lockFail_reg;
    logic [63:0]       flink;
    logic [63:0]       blink;
    logic [63:0]       hdrSext;
    logic [63:0]       entrySum;
    logic [63:0]       entryCalc;
    logic [63:0]       neighSum;
    logic [63:0]       neighCalc;
    logic [63:0]       linkSext;
    logic [63:0]       statusCalc;
    logic              isQuad;
    logic              isChecked;
    logic              barrierState;

    assign isQuad       = (op_reg == iqr_pkg::IQR_OP_QHEAD_RES);
    assign isChecked    = (op_reg == iqr_pkg::IQR_OP_LTAIL_CHK);
    assign barrierState = (state_reg == S_MB1) || (state_reg == S_MB2) || (state_reg == S_MB3);

    // Longword halves of the locked header, each sign extended
    iqr_sext32 uFlink (.value(tmp0_reg), .result(flink));
    assign blink = {{32{tmp0_reg[63]}}, tmp0_reg[63:32]};
    iqr_sext32 uHdr (.value(headerAddress), .result(hdrSext));
    iqr_sext32 uLink (.value(memRdata), .result(linkSext));

    // Removed entry: header plus forward (head) or backward (tail) offset
    assign entrySum = isQuad ? hdr_reg + tmp0_reg : hdr_reg + blink;
    iqr_sext32 uEntry (.value(entrySum), .result(entryCalc));
    assign neighSum = isQuad ? entry_reg + memRdata : entry_reg + linkSext;
    iqr_sext32 uNeigh (.value(neighSum), .result(neighCalc));

    iqr_status_pick uStatus (
        .origFlink(isQuad ? tmp0_reg : flink),
        .neighbour(neigh_reg),
        .header   (hdr_reg),
        .status   (statusCalc)
    );

    // Sequencer; start is only sampled in idle so a removal is never interrupted
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= S_IDLE;
            op_reg      <= iqr_pkg::IQR_OP_QHEAD_RES;
            hdr_reg     <= 64'h0000_0000_0000_0000;
            tmp0_reg    <= 64'h0000_0000_0000_0000;
            entry_reg   <= 64'h0000_0000_0000_0000;
            neigh_reg   <= 64'h0000_0000_0000_0000;
            retry_reg   <= 8'h00;
            pendExc_reg <= iqr_pkg::IQR_EXC_NONE;
            lockFail_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        op_reg      <= opSel;
                        hdr_reg     <= headerAddress;
                        retry_reg   <= RETRY_LIMIT;
                        pendExc_reg <= iqr_pkg::IQR_EXC_NONE;
                        lockFail_reg <= 1'b0;
                        if (opSel == iqr_pkg::IQR_OP_LTAIL_CHK &&
                            (headerAddress[2:0] != 3'b000 || hdrSext != headerAddress)) begin
                            pendExc_reg <= iqr_pkg::IQR_EXC_ILLEGAL_OPERAND;
                            state_reg   <= S_FINISH;
                        end else begin
                            state_reg <= S_LLREAD;
                        end
                    end
                end
                S_LLREAD: begin
                    if (memAck) begin
                        tmp0_reg  <= memRdata;
                        lockFail_reg <= memRdata[`IQR_LOCK_BIT];
                        state_reg <= memRdata[`IQR_LOCK_BIT] ? S_FINISH : S_CONDWR;
                    end
                end
                S_CONDWR: begin
                    if (memAck) begin
                        retry_reg <= retry_reg - 8'h01;
                        if (memCondOk) begin
                            state_reg <= S_MB1;
                        end else if (retry_reg == 8'h01) begin
                            lockFail_reg <= 1'b1;
                            state_reg <= S_FINISH;
                        end else begin
                            state_reg <= S_LLREAD;
                        end
                    end
                end
                S_MB1: begin
                    if (barrierAck) begin
                        entry_reg <= isQuad ? entrySum : entryCalc;
                        if (isChecked) begin
                            state_reg <= S_CHKOFS;
                        end else if (isQuad && tmp0_reg == 64'h0000_0000_0000_0000) begin
                            neigh_reg <= hdr_reg;
                            state_reg <= S_WRLINK1;
                        end else begin
                            state_reg <= S_RDLINK;
                        end
                    end
                end
                S_CHKOFS: begin
                    if (blink[2:0] != 3'b000) begin
                        pendExc_reg <= iqr_pkg::IQR_EXC_ILLEGAL_OPERAND;
                        state_reg   <= S_RESTORE;
                    end else begin
                        state_reg <= S_PROBE1;
                    end
                end
                S_PROBE1, S_PROBE2: begin
                    if (memAck) begin
                        if (memProbeFault) begin
                            pendExc_reg <= iqr_pkg::IQR_EXC_MEM_FAULT;
                            state_reg   <= S_RESTORE;
                        end else if (state_reg == S_PROBE1 && flink != 64'h0000_0000_0000_0000) begin
                            state_reg <= S_PROBE2;
                        end else begin
                            state_reg <= S_RDLINK;
                        end
                    end
                end
                S_RDLINK: begin
                    if (memAck) begin
                        neigh_reg <= isQuad ? neighSum : neighCalc;
                        state_reg <= isChecked ? S_PREDCHK : S_WRLINK1;
                    end
                end
                S_PREDCHK: begin
                    if (neigh_reg[2:0] != 3'b000) begin
                        pendExc_reg <= iqr_pkg::IQR_EXC_ILLEGAL_OPERAND;
                        state_reg   <= S_RESTORE;
                    end else begin
                        state_reg <= S_WRLINK1;
                    end
                end
                S_WRLINK1: begin
                    if (memAck) begin
                        if (isQuad) begin
                            state_reg <= S_MB2;
                        end else begin
                            state_reg <= (neigh_reg == hdr_reg) ? S_WRHDR : S_WRFWD;
                        end
                    end
                end
                S_MB2, S_MB3: begin
                    if (barrierAck) begin
                        state_reg <= S_WRHDR;
                    end
                end
                S_WRFWD: begin
                    if (memAck) begin
                        state_reg <= S_MB3;
                    end
                end
                S_WRHDR, S_RESTORE: begin
                    if (memAck) begin
                        state_reg <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Memory request decode
    always_comb begin
        memReq      = 1'b0;
        memKind     = iqr_pkg::IQR_MEM_READ;
        memProbe    = 1'b0;
        memAddr     = hdr_reg;
        memWdata    = 64'h0000_0000_0000_0000;
        memLongword = !isQuad;
        case (state_reg)
            S_LLREAD: begin
                memReq      = 1'b1;
                memKind     = iqr_pkg::IQR_MEM_LOCKED_READ;
                memLongword = 1'b0;
            end
            S_CONDWR: begin
                memReq      = 1'b1;
                memKind     = iqr_pkg::IQR_MEM_COND_WRITE;
                memWdata    = tmp0_reg | 64'h0000_0000_0000_0001;
                memLongword = 1'b0;
            end
            S_PROBE1: begin
                memReq   = 1'b1;
                memProbe = 1'b1;
                memAddr  = entry_reg + `IQR_LONG_BLINK_OFS;
            end
            S_PROBE2: begin
                memReq   = 1'b1;
                memProbe = 1'b1;
                memKind  = iqr_pkg::IQR_MEM_WRITE;
                memAddr  = hdr_reg; // Predecessor is unknown until read; header write stands for it
            end
            S_RDLINK: begin
                memReq  = 1'b1;
                memAddr = isQuad ? entry_reg : entry_reg + `IQR_LONG_BLINK_OFS;
            end
            S_WRLINK1: begin
                memReq  = 1'b1;
                memKind = iqr_pkg::IQR_MEM_WRITE;
                if (isQuad) begin
                    memAddr  = neigh_reg + `IQR_QUAD_BLINK_OFS;
                    memWdata = hdr_reg - neigh_reg;
                end else begin
                    memAddr  = hdr_reg + `IQR_LONG_BLINK_OFS;
                    memWdata = neigh_reg - hdr_reg;
                end
            end
            S_WRFWD: begin
                memReq   = 1'b1;
                memKind  = iqr_pkg::IQR_MEM_WRITE;
                memAddr  = neigh_reg;
                memWdata = hdr_reg - neigh_reg;
            end
            S_WRHDR: begin
                memReq  = 1'b1;
                memKind = iqr_pkg::IQR_MEM_WRITE;
                if (isQuad) begin
                    memWdata = neigh_reg - hdr_reg;
                end else if (neigh_reg == hdr_reg) begin
                    memWdata = 64'h0000_0000_0000_0000;
                end else begin
                    memWdata = flink;
                end
            end
            S_RESTORE: begin
                memReq      = 1'b1;
                memKind     = iqr_pkg::IQR_MEM_WRITE;
                memWdata    = tmp0_reg;
                memLongword = 1'b0;
            end
            default: begin
                memReq = 1'b0;
            end
        endcase
    end

    assign memoryBarrier = barrierState;
    assign busy          = (state_reg != S_IDLE);

    // Results, registered on completion
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            done         <= 1'b0;
            statusResult <= 64'h0000_0000_0000_0000;
            removedEntry <= 64'h0000_0000_0000_0000;
            exception    <= iqr_pkg::IQR_EXC_NONE;
        end else begin
            done <= (state_reg == S_FINISH);
            if (state_reg == S_FINISH) begin
                exception <= pendExc_reg;
                // Faults leave the previous status and entry in place
                if (lockFail_reg) begin
                    statusResult <= `IQR_ST_LOCKFAIL;
                end else if (pendExc_reg == iqr_pkg::IQR_EXC_NONE) begin
                    statusResult <= statusCalc;
                    removedEntry <= entry_reg;
                end
            end
        end
    end
endmodule

// >>> dv/iqr_remover_sva.sv
`timescale 1ns/1ps
`include "iqr_defs.svh"
module iqr_remover_sva #(
    parameter logic [7:0] RETRY_LIMIT = `IQR_RETRY_INIT
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rstn,
    // Request and result
    input wire logic              start,
    input wire iqr_pkg::iqr_op_t  opSel,
    input wire logic [63:0]       headerAddress,
    input wire logic              busy,
    input wire logic              done,
    input wire logic [63:0]       statusResult,
    input wire iqr_pkg::iqr_exc_t exception,
    // Memory
    input wire logic              memReq,
    input wire iqr_pkg::iqr_mem_t memKind,
    input wire logic [63:0]       memAddr,
    input wire logic [63:0]       memWdata,
    input wire logic              memAck
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [7:0] lrCount;
    logic       badHdr;
    assign badHdr = start && !busy && opSel == iqr_pkg::IQR_OP_LTAIL_CHK
                    && (headerAddress[2:0] != 3'h0 || headerAddress[63:32] != {32{headerAddress[31]}});
    // Counted per operation, so a long run of removals never trips the bound
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lrCount <= 8'h00;
        end else if (start && !busy) begin
            lrCount <= 8'h00;
        end else if (memReq && memAck && memKind == iqr_pkg::IQR_MEM_LOCKED_READ) begin
            lrCount <= lrCount + 8'h01;
        end
    end
    property p_status_code;
        done && exception == iqr_pkg::IQR_EXC_NONE |->
            statusResult inside {`IQR_ST_LOCKFAIL, `IQR_ST_EMPTY, `IQR_ST_REMAIN, `IQR_ST_NOWEMPTY};
    endproperty
    a_status_code: assert property (p_status_code) else $error("bad status code");
    property p_lock_count; lrCount <= RETRY_LIMIT; endproperty
    a_lock_count: assert property (p_lock_count) else $error("too many lock attempts");
    property p_cw_lockbit; memReq && memKind == iqr_pkg::IQR_MEM_COND_WRITE |-> memWdata[0]; endproperty
    a_cw_lockbit: assert property (p_cw_lockbit) else $error("lock bit not set");
    property p_bad_hdr_nomem; badHdr |=> !memReq [*2]; endproperty
    a_bad_hdr_nomem: assert property (p_bad_hdr_nomem) else $error("access on bad header");
    property p_bad_hdr_exc; badHdr |-> ##[1:4] (done && exception == iqr_pkg::IQR_EXC_ILLEGAL_OPERAND); endproperty
    a_bad_hdr_exc: assert property (p_bad_hdr_exc) else $error("bad header not refused");
    property p_req_hold; memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memKind); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_exc_keep; done && exception != iqr_pkg::IQR_EXC_NONE |-> $stable(statusResult); endproperty
    a_exc_keep: assert property (p_exc_keep) else $error("status changed on fault");
    property p_done_pulse; done |=> !done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    c_remain: cover property (done && statusResult == `IQR_ST_REMAIN);
    c_nowempty: cover property (done && statusResult == `IQR_ST_NOWEMPTY);
    c_fault: cover property (done && exception == iqr_pkg::IQR_EXC_MEM_FAULT);
endmodule
bind iqr_remover iqr_remover_sva #(.RETRY_LIMIT(RETRY_LIMIT)) u_sva (.sys_clk, .rstn, .start, .opSel,
    .headerAddress, .busy, .done, .statusResult, .exception, .memReq, .memKind, .memAddr, .memWdata, .memAck);

// >>> dv/iqr_mem_model.sv
`timescale 1ns/1ps
module iqr_mem_model (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rstn,
    // Requests
    input wire logic              memReq,
    input wire iqr_pkg::iqr_mem_t memKind,
    input wire logic              memProbe,
    input wire logic [63:0]       memAddr,
    input wire logic [63:0]       memWdata,
    input wire logic              memLongword,
    input wire logic              memoryBarrier,
    // Answers
    output logic                  memAck = 1'b0,
    output logic [63:0]           memRdata = 64'h0000_0000_0000_0000,
    output logic                  memCondOk = 1'b0,
    output logic                  memProbeFault = 1'b0,
    output logic                  barrierAck = 1'b0
);
    logic [63:0] mem [logic [60:0]];
    logic [63:0] w;
    logic        probeFail = 1'b0;
    int          lat = 0;
    int          condFails = 0;
    int          lockReads = 0;
    int          waitCnt = 0;
    always @(posedge sys_clk) begin
        barrierAck <= memoryBarrier && !barrierAck && rstn;
        if (memAck) begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            waitCnt <= 0;
            if (!memProbe && (memKind == iqr_pkg::IQR_MEM_WRITE || (memKind == iqr_pkg::IQR_MEM_COND_WRITE && memCondOk))) begin
                w = mem.exists(memAddr[63:3]) ? mem[memAddr[63:3]] : 64'h0000_0000_0000_0000;
                // Longword writes touch only the addressed half
                if (!memLongword) w = memWdata;
                else if (memAddr[2]) w[63:32] = memWdata[31:0];
                else w[31:0] = memWdata[31:0];
                mem[memAddr[63:3]] = w;
            end
        end else if (memReq && rstn && waitCnt < lat) begin
            waitCnt <= waitCnt + 1;
        end else if (memReq && rstn) begin
            w = mem.exists(memAddr[63:3]) ? mem[memAddr[63:3]] : 64'h0000_0000_0000_0000;
            memAck <= 1'b1;
            memRdata <= memAddr[2] ? {w[31:0], w[63:32]} : w;
            // A refused conditional write stands for another processor's access
            memCondOk <= condFails == 0;
            memProbeFault <= memProbe && probeFail;
            if (memKind == iqr_pkg::IQR_MEM_COND_WRITE && condFails > 0) condFails = condFails - 1;
            if (memKind == iqr_pkg::IQR_MEM_LOCKED_READ) lockReads = lockReads + 1;
        end else begin
            memRdata <= ~memRdata;
        end
    end
endmodule

// >>> dv/interlocked_queue_remover_tb.sv
`timescale 1ns/1ps
`include "iqr_defs.svh"
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t %s", $time, m); end end
`define QH iqr_pkg::IQR_OP_QHEAD_RES
`define TC iqr_pkg::IQR_OP_LTAIL_CHK
`define TR iqr_pkg::IQR_OP_LTAIL_RES
module interlocked_queue_remover_tb;
    logic              sys_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              start = 1'b0;
    iqr_pkg::iqr_op_t  opSel = `QH;
    logic [63:0]       headerAddress = 64'h0000_0000_0000_0000;
    logic [63:0]       statusResult, removedEntry, memAddr, memWdata, memRdata;
    logic              busy, done, memReq, memProbe, memLongword, memAck, memCondOk;
    logic              memProbeFault, memoryBarrier, barrierAck;
    iqr_pkg::iqr_exc_t exception;
    iqr_pkg::iqr_mem_t memKind;
    int                bad_count = 0;
    int                tests_run = 0;
    int                cycles = 0;
    always #25 sys_clk = ~sys_clk;
    iqr_remover DUT (.sys_clk, .rstn, .start, .opSel, .headerAddress, .busy, .done, .statusResult, .removedEntry,
        .exception, .memReq, .memKind, .memProbe, .memAddr, .memWdata, .memLongword, .memAck, .memRdata,
        .memCondOk, .memProbeFault, .memoryBarrier, .barrierAck);
    iqr_mem_model MEM (.sys_clk, .rstn, .memReq, .memKind, .memProbe, .memAddr, .memWdata, .memLongword,
        .memoryBarrier, .memAck, .memRdata, .memCondOk, .memProbeFault, .barrierAck);
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end
    function automatic logic [63:0] rd(input logic [63:0] a);
        return MEM.mem[a[63:3]];
    endfunction
    task automatic wr(input logic [63:0] a, input logic [63:0] v);
        MEM.mem[a[63:3]] = v;
    endtask
    task automatic run(input iqr_pkg::iqr_op_t op, input logic [63:0] hdr, st, ent,
                       input iqr_pkg::iqr_exc_t ex = iqr_pkg::IQR_EXC_NONE);
        int n;
        @(posedge sys_clk) #2;
        start = 1'b1;
        opSel = op;
        headerAddress = hdr;
        @(posedge sys_clk) #2;
        `CHK(busy, 1'b1, "busy");
        // A second request while busy must be ignored
        opSel = `TC;
        headerAddress = 64'h0000_0000_0000_0007;
        @(posedge sys_clk) #2;
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 500) begin
            @(posedge sys_clk) #2;
            n++;
        end
        `CHK(exception, ex, "exception");
        if (ex == iqr_pkg::IQR_EXC_NONE) begin
            `CHK(statusResult, st, "status");
            `CHK(removedEntry, ent, "entry");
        end
    endtask
    // Quad queue of two entries, all 16-byte aligned
    task automatic t_quad_head();
        wr(64'h1000, 64'h0000_0000_0000_0100);
        wr(64'h1008, 64'h0000_0000_0000_0200);
        wr(64'h1100, 64'h0000_0000_0000_0100);
        wr(64'h1108, 64'hFFFF_FFFF_FFFF_FF00);
        wr(64'h1200, 64'hFFFF_FFFF_FFFF_FE00);
        wr(64'h1208, 64'hFFFF_FFFF_FFFF_FF00);
        MEM.condFails = 1;
        run(`QH, 64'h1000, `IQR_ST_REMAIN, 64'h1100);
        `CHK(rd(64'h1208), 64'hFFFF_FFFF_FFFF_FE00, "successor back link");
        `CHK(rd(64'h1000), 64'h0000_0000_0000_0200, "header forward link");
        run(`QH, 64'h1000, `IQR_ST_NOWEMPTY, 64'h1200);
        `CHK(rd(64'h1008), 64'h0000_0000_0000_0000, "header back link");
        `CHK(rd(64'h1000), 64'h0000_0000_0000_0000, "header released");
        run(`QH, 64'h1000, `IQR_ST_EMPTY, 64'h1000);
    endtask
    // Lock failures must leave the last removed entry in place
    task automatic t_lock();
        wr(64'h1000, 64'h0000_0000_0000_0001);
        run(`QH, 64'h1000, `IQR_ST_LOCKFAIL, 64'h1000);
        `CHK(rd(64'h1000), 64'h0000_0000_0000_0001, "held header touched");
        wr(64'h1000, 64'h0000_0000_0000_0000);
        MEM.condFails = 1000;
        MEM.lockReads = 0;
        run(`QH, 64'h1000, `IQR_ST_LOCKFAIL, 64'h1000);
        `CHK(MEM.lockReads, `IQR_RETRY_INIT, "attempt count");
        `CHK(rd(64'h1000), 64'h0000_0000_0000_0000, "header after retries");
        MEM.condFails = 0;
    endtask
    // Longword queue of two entries, 8-byte aligned
    task automatic t_tail_faults();
        MEM.lockReads = 0;
        run(`TC, 64'h0000_0000_0000_2004, 0, 0, iqr_pkg::IQR_EXC_ILLEGAL_OPERAND);
        run(`TC, 64'h0000_0001_0000_2000, 0, 0, iqr_pkg::IQR_EXC_ILLEGAL_OPERAND);
        `CHK(MEM.lockReads, 0, "access before check");
        wr(64'h2000, 64'h0000_0024_0000_0010);
        run(`TC, 64'h2000, 0, 0, iqr_pkg::IQR_EXC_ILLEGAL_OPERAND);
        `CHK(rd(64'h2000), 64'h0000_0024_0000_0010, "header restore");
        wr(64'h2000, 64'h0000_0020_0000_0010);
        wr(64'h2010, 64'hFFFF_FFF0_0000_0010);
        wr(64'h2020, 64'hFFFF_FFF0_FFFF_FFE0);
        MEM.probeFail = 1'b1;
        run(`TC, 64'h2000, 0, 0, iqr_pkg::IQR_EXC_MEM_FAULT);
        `CHK(rd(64'h2000), 64'h0000_0020_0000_0010, "header restore");
        `CHK(rd(64'h2010), 64'hFFFF_FFF0_0000_0010, "entry touched");
        MEM.probeFail = 1'b0;
    endtask
    task automatic t_tail();
        MEM.lat = 3;
        run(`TR, 64'h2000, `IQR_ST_REMAIN, 64'h2020);
        `CHK(rd(64'h2000), 64'h0000_0010_0000_0010, "header links");
        `CHK(rd(64'h2010), 64'hFFFF_FFF0_FFFF_FFF0, "predecessor link");
        run(`TC, 64'h2000, `IQR_ST_NOWEMPTY, 64'h2010);
        `CHK(rd(64'h2000), 64'h0000_0000_0000_0000, "header emptied");
        MEM.lat = 0;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        #2 rstn = 1'b1;
        t_quad_head();
        t_lock();
        t_tail_faults();
        t_tail();
        conclude();
    end
endmodule
